/* File: verilog/isp_host_pkg.sv */
// Package for the serial in-system programming host controller.
// Assumes a 20 MHz system clock; the millisecond waits derive from it.
package isp_host_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int POWERUP_MS      = 20;
  localparam int ERASE_MS        = 10;
  localparam int FIXED_WAIT_MS   = 4;
  localparam int POWERUP_CYCLES  = CLK_HZ / 1000 * POWERUP_MS;
  localparam int ERASE_CYCLES    = CLK_HZ / 1000 * ERASE_MS;
  localparam int FIXED_CYCLES    = CLK_HZ / 1000 * FIXED_WAIT_MS;
  localparam int SCK_HALF_CYCLES = 4;   // Half serial period: 200 ns
  localparam int RST_PULSE_CYCLES = 4;  // Reset pulse, well over two oscillator cycles
  localparam int MAX_ENABLE_TRIES = 32;

  // ****************************************************************
  // Instruction encodings
  // ****************************************************************
  localparam logic [7:0] OP_ENABLE   = 8'hAC;
  localparam logic [7:0] ENABLE_ECHO = 8'h53;
  localparam logic [7:0] ERASE_B2    = 8'h80;
  localparam logic [7:0] LOCK_B2     = 8'hE0;
  localparam logic [7:0] OP_PREAD    = 8'h20;
  localparam logic [7:0] OP_PWRITE   = 8'h40;
  localparam logic [7:0] OP_EREAD    = 8'hA0;
  localparam logic [7:0] OP_EWRITE   = 8'hC0;
  localparam logic [7:0] OP_CODE     = 8'h30;
  localparam logic [7:0] BUSY_VALUE  = 8'h7F;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;
  localparam int         HBIT_POS    = 3;
  localparam logic [11:0] PROG_LAST  = 12'hFFF;
  localparam logic [8:0]  EE_LAST    = 9'h1FF;

  // ****************************************************************
  // Command types
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_PREAD, CMD_PWRITE, CMD_EREAD, CMD_EWRITE,
    CMD_ERASE, CMD_LOCK, CMD_CODE, CMD_END
  } cmd_e;

  typedef struct packed {
    cmd_e        kind;
    logic        highByte;
    logic [11:0] addr;
    logic [7:0]  data;
    logic        noErase;  // Memory not chip-erased before this write
  } cmd_s;

  typedef struct packed {
    logic       ok;
    logic       noDevice;
    logic [7:0] data;
  } rsp_s;

endpackage

/* File: verilog/isp_shifter.sv */
// Four-byte serial shifter driving the programming link as master.
// Assumes the device samples on the rising edge and changes on falling.
`timescale 1ns/1ps
`default_nettype none
module isp_shifter
  import isp_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Frame request and result
  input  wire logic        start,
  input  wire logic [31:0] frame,
  output logic             done,
  output logic [31:0]      received,
  // Link pins
  output logic             sck,
  output logic             mosi,
  input  wire logic        misoSync
);

  // ****************************************************************
  // Bit timing
  // ****************************************************************
  logic [2:0]  halfCount;
  logic [5:0]  bitsLeft;
  logic [31:0] txShift;
  logic        busy;
  wire         halfTick  = busy && (halfCount == 3'(SCK_HALF_CYCLES - 1));
  wire         lastBit   = (bitsLeft == 6'h01);

  // Mode 0: data set while clock low, read just before the rising edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      halfCount <= 3'h0;
      bitsLeft  <= 6'h00;
      txShift   <= 32'h0;
      received  <= 32'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
      sck       <= 1'b0;
      mosi      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        bitsLeft  <= 6'h20;
        halfCount <= 3'h0;
        txShift   <= {frame[30:0], 1'b0};
        mosi      <= frame[31];
      end else if (busy) begin
        halfCount <= halfTick ? 3'h0 : halfCount + 3'h1;
        if (halfTick && !sck) begin
          sck      <= 1'b1;
          // Late sample of the device output, settled long before
          received <= {received[30:0], misoSync};
        end else if (halfTick) begin
          sck      <= 1'b0;
          bitsLeft <= bitsLeft - 6'h01;
          mosi     <= txShift[31];
          txShift  <= {txShift[30:0], 1'b0};
          if (lastBit) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: verilog/isp_host.sv */
// Host controller for the serial in-system programming port.
// Assumes misoPin is asynchronous; commands come from logic on clock.
`timescale 1ns/1ps
`default_nettype none
module isp_host
  import isp_host_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYCLES,
  parameter int ERASE_WAIT   = ERASE_CYCLES,
  parameter int FIXED_WAIT   = FIXED_CYCLES,
  parameter int POLL_LIMIT   = 4096
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Command port
  input  wire logic cmdValid,
  input  wire cmd_s cmd,
  output logic      cmdReady,
  output logic      rspValid,
  output rsp_s      rsp,
  // Device pins
  output logic      targetReset,
  output logic      sckPin,
  output logic      mosiPin,
  input  wire logic misoPin
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // Refused at elaboration: the timer is 20 bits and the poll counter 13
  if (POWERUP_WAIT < 1 || ERASE_WAIT < 1 || FIXED_WAIT < 1 || POLL_LIMIT < 1) begin
    $error("isp_host: wait counts must be at least one");
  end
  if (POWERUP_WAIT >= 2**20 || ERASE_WAIT >= 2**20 || FIXED_WAIT >= 2**20 ||
      POLL_LIMIT >= 2**13) begin
    $error("isp_host: wait counts exceed the timer width");
  end

  typedef enum logic [3:0] {
    ST_RSTPULSE, ST_POWERWAIT, ST_ENABLE, ST_ENCHECK, ST_NUDGE, ST_IDLE,
    ST_SEND, ST_POLL, ST_POLLCHECK, ST_FIXWAIT, ST_ERASEWAIT, ST_REPLY,
    ST_RELEASED, ST_DEAD
  } state_e;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  logic misoMeta;
  logic misoSync;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
    end else begin
      misoMeta <= misoPin;
      misoSync <= misoMeta;
    end
  end

  // ****************************************************************
  // State and storage
  // ****************************************************************
  state_e      state;
  logic [19:0] timer;
  logic [5:0]  tries;
  logic [12:0] pollCount;
  cmd_s        held;
  logic        erased;
  logic        shStart;
  logic [31:0] shFrame;
  logic        shDone;
  logic [31:0] shRecv;
  logic        shSck;
  logic        shMosi;
  logic        nudgeSck;

  // ****************************************************************
  // Frame encoding and decisions
  // ****************************************************************
  wire [3:0]  addrHigh = held.addr[11:8];
  wire [7:0]  addrLow  = held.addr[7:0];
  wire [7:0]  hOp      = 8'(1 << HBIT_POS) & {8{held.highByte}};
  wire [31:0] enFrame  = {OP_ENABLE, ENABLE_ECHO, 16'h0000};
  wire [31:0] cmdFrame =
    (held.kind == CMD_PREAD)  ? {OP_PREAD | hOp, 4'h0, addrHigh, addrLow, 8'h00} :
    (held.kind == CMD_PWRITE) ? {OP_PWRITE | hOp, 4'h0, addrHigh, addrLow, held.data} :
    // EEPROM read, high address bit in byte two
    (held.kind == CMD_EREAD)  ? {OP_EREAD, 7'h00, held.addr[8], addrLow, 8'h00} :
    (held.kind == CMD_EWRITE) ? {OP_EWRITE, 7'h00, held.addr[8], addrLow, held.data} :
    (held.kind == CMD_ERASE)  ? {OP_ENABLE, ERASE_B2, 16'h0000} :
    // lock bits in positions two and one
    (held.kind == CMD_LOCK)   ? {OP_ENABLE, LOCK_B2 | {5'h00, held.data[2:1], 1'b0}, 16'h0000} :
    {OP_CODE, 8'h00, 6'h00, held.addr[1:0], 8'h00};
  // Read-back frame used for polling the written location
  wire [31:0] pollFrame = (held.kind == CMD_PWRITE) ?
    {OP_PREAD | hOp, 4'h0, addrHigh, addrLow, 8'h00} :
    {OP_EREAD, 7'h00, held.addr[8], addrLow, 8'h00};
  wire        isWrite   = (held.kind == CMD_PWRITE) || (held.kind == CMD_EWRITE);
  // fixed wait where polling cannot tell completion
  wire        needFixed = (held.data == BUSY_VALUE) ||
                          (held.noErase && held.data == ERASED_VALUE);
  // skip erased-value writes on an erased chip
  wire        skipWrite = isWrite && erased && !held.noErase && held.data == ERASED_VALUE;
  wire        addrBad   = (held.kind == CMD_EWRITE || held.kind == CMD_EREAD) ?
                          (held.addr > {3'h0, EE_LAST}) : (held.addr > PROG_LAST);
  wire        timerDone = (timer == 20'h0);
  // echo seen in the third byte
  wire        echoOk    = (shRecv[15:8] == ENABLE_ECHO);
  // polled value matches once writing completes
  wire        pollOk    = (shRecv[7:0] == held.data) && (shRecv[7:0] != BUSY_VALUE);
  wire        pollGiveUp = (pollCount == 13'(POLL_LIMIT));

  // ****************************************************************
  // Control sequence
  // ****************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // reset pulse with serial clock held low
      state       <= ST_RSTPULSE;
      timer       <= 20'(RST_PULSE_CYCLES);
      targetReset <= 1'b1;
      tries       <= 6'h00;
      pollCount   <= 13'h0;
      held        <= '0;
      erased      <= 1'b0;
      shStart     <= 1'b0;
      shFrame     <= 32'h0;
      nudgeSck    <= 1'b0;
      cmdReady    <= 1'b0;
      rspValid    <= 1'b0;
      rsp         <= '0;
    end else begin
      shStart  <= 1'b0;
      rspValid <= 1'b0;
      if (!timerDone)
        timer <= timer - 20'h1;
      unique case (state)
        ST_RSTPULSE: if (timerDone) begin
          targetReset <= 1'b0;
          timer       <= 20'(POWERUP_WAIT);
          state       <= ST_POWERWAIT;
        end
        ST_POWERWAIT: if (timerDone) begin
          state <= ST_ENABLE;
        end
        ST_ENABLE: begin
          shFrame <= enFrame;
          shStart <= 1'b1;
          state   <= ST_ENCHECK;
        end
        ST_ENCHECK: if (shDone) begin
          if (echoOk) begin
            tries    <= 6'h00;
            cmdReady <= 1'b1;
            state    <= ST_IDLE;
          end else if (tries == 6'(MAX_ENABLE_TRIES - 1)) begin
            rsp      <= '{ok: 1'b0, noDevice: 1'b1, data: 8'h00};
            rspValid <= 1'b1;
            state    <= ST_DEAD;
          end else begin
            tries    <= tries + 6'h01;
            nudgeSck <= 1'b1;
            timer    <= 20'(SCK_HALF_CYCLES);
            state    <= ST_NUDGE;
          end
        end
        ST_NUDGE: if (timerDone) begin
          if (nudgeSck) begin
            nudgeSck <= 1'b0;
            timer    <= 20'(SCK_HALF_CYCLES);
          end else begin
            state <= ST_ENABLE;
          end
        end
        ST_IDLE: if (cmdValid) begin
          held     <= cmd;
          cmdReady <= 1'b0;
          state    <= ST_SEND;
        end
        ST_SEND: begin
          if (held.kind == CMD_END) begin
            // release reset to end the session
            targetReset <= 1'b1;
            rsp         <= '{ok: 1'b1, noDevice: 1'b0, data: 8'h00};
            state       <= ST_RELEASED;
            rspValid    <= 1'b1;
          end else if (addrBad || skipWrite) begin
            rsp   <= '{ok: skipWrite, noDevice: 1'b0, data: 8'h00};
            state <= ST_REPLY;
          end else if (!shStart && !shDone) begin
            shFrame   <= cmdFrame;
            shStart   <= 1'b1;
            pollCount <= 13'h0;
            state     <= ST_POLL;
          end
        end
        ST_POLL: if (shDone) begin
          rsp <= '{ok: 1'b1, noDevice: 1'b0, data: shRecv[7:0]};
          if (held.kind == CMD_ERASE) begin
            // erase wait then reset pulse and re-enable
            erased <= 1'b1;
            timer  <= 20'(ERASE_WAIT);
            state  <= ST_ERASEWAIT;
          end else if (isWrite && needFixed) begin
            timer <= 20'(FIXED_WAIT);
            state <= ST_FIXWAIT;
          end else if (isWrite) begin
            shFrame <= pollFrame;
            shStart <= 1'b1;
            state   <= ST_POLLCHECK;
          end else begin
            state <= ST_REPLY;
          end
        end
        // data polling until the written value reads back or POLL_LIMIT is reached
        ST_POLLCHECK: if (shDone) begin
          pollCount <= pollCount + 13'h1;
          if (pollOk || pollGiveUp) begin
            rsp   <= '{ok: pollOk, noDevice: 1'b0, data: shRecv[7:0]};
            state <= ST_REPLY;
          end else begin
            shFrame <= pollFrame;
            shStart <= 1'b1;
          end
        end
        ST_FIXWAIT: if (timerDone) begin
          state <= ST_REPLY;
        end
        ST_ERASEWAIT: if (timerDone) begin
          if (!targetReset) begin
            targetReset <= 1'b1;
            timer       <= 20'(RST_PULSE_CYCLES);
          end else begin
            targetReset <= 1'b0;
            rspValid    <= 1'b1;
            state       <= ST_ENABLE;
          end
        end
        ST_REPLY: begin
          rspValid <= 1'b1;
          cmdReady <= 1'b1;
          state    <= ST_IDLE;
        end
        ST_RELEASED, ST_DEAD: begin
          cmdReady <= 1'b0;
        end
        default: state <= ST_DEAD;
      endcase
    end
  end

  // ****************************************************************
  // Serial shifter and pin drive
  // ****************************************************************
  isp_shifter shifter (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .start    (shStart),
    .frame    (shFrame),
    .done     (shDone),
    .received (shRecv),
    .sck      (shSck),
    .mosi     (shMosi),
    .misoSync (misoSync)
  );

  // Registered pins; clock low outside frames except the retry pulse
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sckPin  <= 1'b0;
      mosiPin <= 1'b0;
    end else begin
      sckPin  <= shSck | nudgeSck;
      mosiPin <= shMosi;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Length of the current target reset pulse, saturating
  logic [5:0] pulseAge;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      pulseAge <= 6'h0;
    else
      pulseAge <= !targetReset ? 6'h0 : pulseAge + {5'h0, pulseAge != 6'h3F};
  end

  reset_width_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(targetReset) |-> pulseAge >= 6'(RST_PULSE_CYCLES))
    else $error("target reset pulse too short");

  reset_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    shStart |-> !targetReset) else $error("frame started with reset high");
  // no more than the permitted attempts
  tries_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
    tries < 6'(MAX_ENABLE_TRIES)) else $error("too many enable attempts");
  dead_report_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ENCHECK && shDone && !echoOk && tries == 6'(MAX_ENABLE_TRIES - 1))
    |=> rspValid && rsp.noDevice)
    else $error("no-device report missing");
  // serial clock low while reset pulses at start
  sck_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_RSTPULSE) |-> !sckPin) else $error("serial clock high in reset pulse");
  // reset pulse ahead of re-enable after erase
  erase_reset_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_ERASEWAIT && timerDone && targetReset) |=> state == ST_ENABLE && !targetReset)
    else $error("erase restart sequence broken");
  release_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_RELEASED) |=> targetReset) else $error("reset not held after session");
  fixed_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(state == ST_FIXWAIT) |-> timer == 20'(FIXED_WAIT))
    else $error("fixed wait not loaded");
  // enable not sent before power-up wait
  power_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_POWERWAIT && !timerDone) |=> state != ST_ENABLE)
    else $error("enable sent early");

endmodule
`default_nettype wire

/* File: tb/isp_device_model.sv */
// Behavioural serial-programmed target for the host bench.
// Assumes the host keeps the serial clock low outside frames.
`timescale 1ns/1ps
`default_nettype none
module isp_device_model
  import isp_host_pkg::*;
#(
  parameter int         BUSY_NS   = 20000,
  parameter logic [7:0] CODE_BASE = 8'h5A  // Arbitrary code value
) (
  // Device pins
  input  wire logic rstPin,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  // Fault injection
  input  wire logic noEcho
);
  logic [31:0] sh;
  logic [7:0]  outSh, misoQ;
  logic [7:0]  prog [8192];
  logic [7:0]  ee [512];
  logic [1:0]  lockBits;
  logic [13:0] busyKey;
  logic        enabled, busy;
  int          bits, writes, frames;

  // Word/byte or EEPROM byte index, one key space for both arrays
  function automatic logic [13:0] key(logic [23:0] s);
    if (s[23:16] == OP_EREAD || s[23:16] == OP_EWRITE)
      return {1'b1, 4'h0, s[8], s[7:0]};
    return {1'b0, s[11:8], s[7:0], s[19]};
  endfunction

  function automatic logic [7:0] rd(logic [23:0] s);
    logic [13:0] k;
    k = key(s);
    if (busy && k == busyKey) return BUSY_VALUE;
    if ((s[23:16] & 8'hF7) == OP_PREAD) return prog[k[12:0]];
    if (s[23:16] == OP_EREAD) return ee[k[8:0]];
    if (s[23:16] == OP_CODE) return CODE_BASE + 8'(s[1:0]);
    return 8'h00;
  endfunction

  initial begin
    foreach (prog[i]) prog[i] = 8'hFF;
    foreach (ee[i]) ee[i] = 8'h00;
    lockBits = 2'b11;
    busy = 0;
    writes = 0;
    frames = 0;
    misoQ = 8'h00;
    outSh = 8'h00;
  end

  // sample on rising edge, echo, gate on enable
  always @(posedge sck or posedge rstPin) begin
    if (rstPin) begin
      bits = 0;
      enabled = 0;
    end else begin
      sh = {sh[30:0], mosi};
      bits = bits + 1;
      if (bits % 32 == 16) outSh = noEcho ? ~sh[7:0] : sh[7:0];
      if (bits % 32 == 24) outSh = rd(sh[23:0]);
      if (bits % 32 == 0) execute(sh);
    end
  end

  // one byte per write, others ignored
  task automatic execute(logic [31:0] f);
    logic [13:0] k;
    k = key(f[31:8]);
    frames++;
    if (f[31:24] == OP_ENABLE && f[23:16] == ENABLE_ECHO) enabled = 1;
    else if (!enabled) return;
    else if (f[31:24] == OP_ENABLE && f[23:21] == 3'b100) begin
      foreach (prog[i]) prog[i] = 8'hFF;
      foreach (ee[i]) ee[i] = 8'hFF;
      lockBits = 2'b11;
    end else if (f[31:24] == OP_ENABLE && f[23:21] == 3'b111)
      lockBits = lockBits & f[18:17];
    else if ((f[31:24] & 8'hF7) == OP_PWRITE || f[31:24] == OP_EWRITE) begin
      // Flash only clears bits; EEPROM erases itself first
      if (k[13]) ee[k[8:0]] = f[7:0];
      else prog[k[12:0]] = prog[k[12:0]] & f[7:0];
      writes++;
      busy = 1;
      busyKey = k;
      fork
        begin
          #(BUSY_NS);
          busy = 0;
        end
      join_none
    end
  endtask

  // change output on the falling edge
  always @(negedge sck) begin
    misoQ <= {misoQ[6:0], outSh[7]};
    outSh <= {outSh[6:0], ~outSh[7]};
  end

  // Not selected: the line shows the last bit inverted; a missing target leaves
  // the line at its pull-up level, so no echo can appear by chance
  assign miso = noEcho ? 1'b1 : (rstPin ? ~misoQ[0] : misoQ[0]);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the programming host controller.
// Assumes the device model stands on the far side of the link pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import isp_host_pkg::*;
;
  logic clock, sys_rst, cmdValid, cmdReady, rspValid;
  logic targetReset, sckPin, mosiPin, misoPin, noEcho;
  cmd_s cmd;
  rsp_s rsp, got;
  int   failures, tests_run, cycles;

  isp_host #(.POWERUP_WAIT(50), .ERASE_WAIT(50), .FIXED_WAIT(500), .POLL_LIMIT(8))
  u_isp_host (.clock(clock), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp), .targetReset(targetReset),
    .sckPin(sckPin), .mosiPin(mosiPin), .misoPin(misoPin));
  isp_device_model u_isp_device_model (.rstPin(targetReset), .sck(sckPin),
    .mosi(mosiPin), .miso(misoPin), .noEcho(noEcho));

  always #25 clock = ~clock;

  // Hang guard, well above the roughly 16000 cycles of the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      $display("[ERR] run length expected end seen hang");
      tally_and_finish();
    end
  end

  task automatic chk8(string what, logic [7:0] exp, logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(string what, logic exp, logic seen);
    chk8(what, {7'h00, exp}, {7'h00, seen});
  endtask

  // One command, driven for one cycle once ready is seen, then its response
  task automatic issue(cmd_e k, logic h, logic [11:0] a, logic [7:0] d, logic ne);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    cmd = '{k, h, a, d, ne};
    cmdValid = 1;
    @(negedge clock);
    cmdValid = 0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    got = rsp;
    chk1("response", 1'b1, rspValid);
  endtask

  task automatic do_reset();
    sys_rst = 1;
    repeat (12) @(negedge clock);
    chk1("reset pin", 1'b1, targetReset);
    chk1("clock pin", 1'b0, sckPin);
    sys_rst = 0;
  endtask

  task automatic t_enable();
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk1("ready", 1'b1, cmdReady);
    chk1("late enable", 1'b1, n > 300);
    chk1("enabled", 1'b1, u_isp_device_model.enabled);
    $display("enable test done");
  endtask

  task automatic t_prog();
    issue(CMD_PWRITE, 1, 12'hFFF, 8'hA5, 0);
    chk1("pwrite ok", 1'b1, got.ok);
    issue(CMD_PREAD, 1, 12'hFFF, 8'h00, 0);
    chk8("pread hi", 8'hA5, got.data);
    issue(CMD_PREAD, 0, 12'hFFF, 8'h00, 0);
    chk8("pread lo", 8'hFF, got.data);
    $display("program test done");
  endtask

  task automatic t_eeprom();
    logic [8:0] a [3] = '{9'h1FF, 9'h000, 9'h005};
    logic [7:0] d [3] = '{8'h3C, 8'h7F, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      issue(CMD_EWRITE, 0, {3'b000, a[i]}, d[i], i == 2);
      chk1("ewrite ok", 1'b1, got.ok);
      issue(CMD_EREAD, 0, {3'b000, a[i]}, 8'h00, 0);
      chk8("eread", d[i], got.data);
    end
    $display("eeprom test done");
  endtask

  task automatic t_misc();
    issue(CMD_LOCK, 0, 12'h000, 8'hFB, 0);
    chk8("lock", 8'h01, {6'h00, u_isp_device_model.lockBits});
    for (int i = 0; i < 3; i++) begin
      issue(CMD_CODE, 0, 12'(i), 8'h00, 0);
      chk8("code", 8'h5A + 8'(i), got.data);
    end
    $display("lock and code test done");
  endtask

  task automatic t_range();
    int f;
    f = u_isp_device_model.frames;
    issue(CMD_EREAD, 0, 12'h200, 8'h00, 0);
    chk1("range ok", 1'b0, got.ok);
    chk8("range frames", 8'(f), 8'(u_isp_device_model.frames));
    $display("range test done");
  endtask

  task automatic t_erase();
    int w;
    issue(CMD_ERASE, 0, 12'h000, 8'h00, 0);
    chk1("erase ok", 1'b1, got.ok);
    issue(CMD_PREAD, 1, 12'hFFF, 8'h00, 0);
    chk8("erased prog", 8'hFF, got.data);
    issue(CMD_EREAD, 0, 12'h1FF, 8'h00, 0);
    chk8("erased ee", 8'hFF, got.data);
    w = u_isp_device_model.writes;
    issue(CMD_PWRITE, 0, 12'h010, 8'hFF, 0);
    chk1("skip ok", 1'b1, got.ok);
    chk8("skip writes", 8'(w), 8'(u_isp_device_model.writes));
    $display("erase test done");
  endtask

  task automatic t_end();
    issue(CMD_END, 0, 12'h000, 8'h00, 0);
    repeat (2) @(negedge clock);
    chk1("released", 1'b1, targetReset);
    $display("end test done");
  endtask

  task automatic t_nodev();
    int n;
    noEcho = 1;
    do_reset();
    n = 0;
    while (rspValid !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    chk1("no device", 1'b1, rsp.noDevice);
    chk1("dead", 1'b0, cmdReady);
    $display("no device test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clock = 0;
    sys_rst = 1;
    cmdValid = 0;
    cmd = '0;
    noEcho = 0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    @(negedge clock);
    do_reset();
    t_enable();
    t_prog();
    t_eeprom();
    t_misc();
    t_range();
    t_erase();
    t_end();
    t_nodev();
    tally_and_finish();
  end
endmodule
`default_nettype wire
